//--- rtl/spi_flag_logic.sv
// SPI status flags, receive holding register and transmit FIFO path
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Small valid/ready FIFO
// ****************************************
module spi_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk, // System clock
	input wire logic rstn, // Async reset, low
	input wire logic in_valid, // Write strobe
	output logic in_ready, // Room for a word
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Word available
	input wire logic out_ready, // Drain strobe
	output logic [WIDTH-1:0] out_data // Head word
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] COUNT_FULL = (PW+1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0] count;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	assign in_ready = (count != COUNT_FULL);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			wr_ptr <= push ? PW'(wr_ptr + 1'b1) : wr_ptr;
			rd_ptr <= pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
			count <= (PW+1)'(count + push - pop);
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule

// ****************************************
// Status flag block
// ****************************************
// Functional notes
// RULE_01 - Busy bit 7 is high while a slave or master transfer runs.
// RULE_02 - SS asserted by another master during our master transfer sets bit 6.
// RULE_03 - Multimaster error stays set until software writes 0 to it.
// RULE_04 - Byte completing while holding register unread sets overrun bit 5.
// RULE_05 - On overrun with overwrite enabled the new byte replaces holding data.
// RULE_06 - Reading the receive holding register clears the overrun flag.
// RULE_07 - Ready bit 4 sets on new holding data, clears when it is read.
// RULE_08 - With mode bit 0, interrupt rises when ready sets, if enabled.
// RULE_09 - With mode bit 0, unread holding register at byte end stops and drops SS.
// RULE_10 - Receive full bit 3 sets when receive buffer fills, clears on read.
// RULE_11 - Underflow bit 2 sets when transmit FIFO runs dry.
// RULE_12 - Software keeps the transfer mode bit at 1 for normal operation.
// RULE_13 - On overrun without overwrite the new byte is dropped.
module spi_status_flag_logic (
	input wire logic clk, // 250 MHz system clock
	input wire logic rstn, // Async reset, low
	input wire spi_flag_pkg::sfr_req_s sfr_req, // SFR access from core
	output logic [7:0] sfr_rdata, // Read data, one cycle later
	input wire logic sclk, // Link clock pin
	input wire logic ss_n, // Slave select pin
	input wire logic mosi, // Serial data in
	output logic miso, // Serial data out
	output logic miso_oe, // High while driving data out
	input wire logic master_active, // Master engine transferring
	output logic ss_out_n, // Master slave select drive
	input wire logic irq_enable, // SPI/I2C interrupt enable
	output logic irq, // Interrupt request
	output logic tx_holding_ready // Transmit FIFO has room
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic sclk_meta;
	logic sclk_s;
	logic sclk_d;
	logic ss_meta;
	logic ss_s;
	logic ss_d;
	logic mosi_meta;
	logic mosi_s;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sclk_meta <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			ss_meta <= 1'b1;
			ss_s <= 1'b1;
			ss_d <= 1'b1;
			mosi_meta <= 1'b0;
			mosi_s <= 1'b0;
		end
		else
		begin
			sclk_meta <= sclk;
			sclk_s <= sclk_meta;
			sclk_d <= sclk_s;
			ss_meta <= ss_n;
			ss_s <= ss_meta;
			ss_d <= ss_s;
			mosi_meta <= mosi;
			mosi_s <= mosi_meta;
		end
	end

	wire sclk_rise = sclk_s & ~sclk_d;
	wire sclk_fall = ~sclk_s & sclk_d;
	wire ss_fall = ~ss_s & ss_d;

	// ****************************************
	// Register decode
	// ****************************************
	logic [7:0] config_one;
	logic [7:0] rx_hold;
	logic multimaster_error_flag;
	logic overrun;
	logic ready;
	logic rx_full;
	logic underflow;
	logic busy;
	logic stop_latch;

	wire hit_cfg = sfr_req.addr == spi_flag_pkg::ADDR_CONFIG_ONE;
	wire hit_status = sfr_req.addr == spi_flag_pkg::ADDR_STATUS;
	wire hit_tx = sfr_req.addr == spi_flag_pkg::ADDR_TX_HOLD;
	wire hit_rx = sfr_req.addr == spi_flag_pkg::ADDR_RX_HOLD;
	wire cfg_wr = sfr_req.wr & hit_cfg;
	wire status_wr = sfr_req.wr & hit_status;
	wire tx_wr = sfr_req.wr & hit_tx;
	wire rx_read = sfr_req.rd & hit_rx;
	wire transfer_irq_mode = config_one[spi_flag_pkg::CFG_TRANSFER_IRQ_MODE];
	wire overwrite_en = config_one[spi_flag_pkg::CFG_OVERWRITE];
	wire ss_in_en = config_one[spi_flag_pkg::CFG_SS_IN_EN];

	wire [7:0] status_word = {busy, multimaster_error_flag, overrun, ready, rx_full,
		underflow, 2'b00};
	wire [7:0] read_mux =
		hit_status ? status_word :
		hit_rx ? rx_hold :
		hit_cfg ? config_one : spi_flag_pkg::BYTE_ZERO;

	// ****************************************
	// Slave link shifter
	// ****************************************
	spi_flag_pkg::link_state_e state;
	spi_flag_pkg::link_state_e next_state;
	logic [2:0] bit_cnt;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic fifo_valid;
	logic fifo_in_ready;
	logic [7:0] fifo_data;

	wire shifting = state == spi_flag_pkg::LINK_SHIFT;
	wire frame_start = ss_fall & ~master_active;
	wire byte_done = shifting & sclk_rise &
		(bit_cnt == spi_flag_pkg::BIT_CNT_LAST);
	// Reload at frame start and straight after each eighth sample
	wire tx_load = frame_start | byte_done;
	wire [7:0] tx_next_byte = fifo_valid ? fifo_data :
		spi_flag_pkg::BYTE_ZERO;
	wire [7:0] rx_byte = {rx_shift[6:0], mosi_s};

	always_comb
	begin
		next_state = state;
		case (state)
			spi_flag_pkg::LINK_IDLE:
				if (frame_start)
					next_state = spi_flag_pkg::LINK_SHIFT;
			spi_flag_pkg::LINK_SHIFT:
				if (ss_s)
					next_state = spi_flag_pkg::LINK_IDLE;
			default:
				next_state = spi_flag_pkg::LINK_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= spi_flag_pkg::LINK_IDLE;
			bit_cnt <= spi_flag_pkg::BIT_CNT_ZERO;
			rx_shift <= spi_flag_pkg::BYTE_ZERO;
		end
		else
		begin
			state <= next_state;
			if (frame_start)
				bit_cnt <= spi_flag_pkg::BIT_CNT_ZERO;
			else if (shifting & sclk_rise)
			begin
				bit_cnt <= 3'(bit_cnt + spi_flag_pkg::BIT_CNT_ONE);
				rx_shift <= rx_byte;
			end
		end
	end

	// Skip the fall right after a reload so bit 7 is not lost
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			tx_shift <= spi_flag_pkg::BYTE_ZERO;
		else if (tx_load)
			tx_shift <= tx_next_byte;
		else if (shifting & sclk_fall & (bit_cnt != spi_flag_pkg::BIT_CNT_ZERO))
			tx_shift <= {tx_shift[6:0], 1'b0};
	end

	// ****************************************
	// Transmit FIFO
	// ****************************************
	// Drain side stalls until the shifter asks for its next byte
	spi_byte_fifo #(
		.WIDTH(spi_flag_pkg::DATA_W),
		.DEPTH(spi_flag_pkg::TX_FIFO_DEPTH)
	) tx_fifo (
		.clk(clk),
		.rstn(rstn),
		.in_valid(tx_wr),
		.in_ready(fifo_in_ready),
		.in_data(sfr_req.wdata),
		.out_valid(fifo_valid),
		.out_ready(tx_load),
		.out_data(fifo_data)
	);

	// ****************************************
	// Flag events
	// ****************************************
	// A read in the same cycle as a byte end counts as in time
	wire overrun_event = byte_done & ready & ~rx_read; // see RULE_04
	wire load_hold = byte_done & (~overrun_event | overwrite_en); // see RULE_05
	wire multimaster_error_flag_set = ss_in_en & master_active & ~ss_s; // see RULE_02
	wire multimaster_error_flag_clr = status_wr & ~sfr_req.wdata[spi_flag_pkg::BIT_MULTIMASTER_ERROR_FLAG];
	wire uf_set = tx_load & ~fifo_valid; // see RULE_11
	wire uf_clr = tx_wr |
		(status_wr & ~sfr_req.wdata[spi_flag_pkg::BIT_UNDERFLOW]);
	wire stop_set = ~transfer_irq_mode & overrun_event & master_active; // see RULE_09

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rx_hold <= spi_flag_pkg::BYTE_ZERO;
		else if (load_hold)
			rx_hold <= rx_byte; // see RULE_13
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ready <= 1'b0;
			overrun <= 1'b0;
			rx_full <= 1'b0;
		end
		else
		begin
			ready <= load_hold | (ready & ~rx_read); // see RULE_07
			overrun <= overrun_event | (overrun & ~rx_read); // see RULE_06
			rx_full <= overrun_event | (rx_full & ~rx_read); // see RULE_10
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			multimaster_error_flag <= 1'b0;
			underflow <= 1'b0;
			busy <= 1'b0;
		end
		else
		begin
			multimaster_error_flag <= multimaster_error_flag_set | (multimaster_error_flag & ~multimaster_error_flag_clr); // see RULE_03
			underflow <= uf_set | (underflow & ~uf_clr);
			busy <= master_active | (next_state == spi_flag_pkg::LINK_SHIFT); // see RULE_01
		end
	end

	// ****************************************
	// Configuration and SFR read port
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			config_one <= spi_flag_pkg::CONFIG_RESET; // see RULE_12
		else if (cfg_wr)
			config_one <= sfr_req.wdata;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sfr_rdata <= spi_flag_pkg::BYTE_ZERO;
		else if (sfr_req.rd)
			sfr_rdata <= read_mux;
	end

	// ****************************************
	// Pin and interrupt outputs
	// ****************************************
	// Stop holds until the master engine ends its transfer
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			stop_latch <= 1'b0;
			ss_out_n <= 1'b1;
		end
		else
		begin
			stop_latch <= master_active & (stop_latch | stop_set);
			ss_out_n <= ~(master_active & ~stop_latch & ~stop_set); // see RULE_09
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			miso <= 1'b0;
			miso_oe <= 1'b0;
			irq <= 1'b0;
			tx_holding_ready <= 1'b0;
		end
		else
		begin
			miso <= tx_shift[7];
			miso_oe <= shifting & ~ss_s & ~master_active;
			irq <= irq_enable & ~transfer_irq_mode & ready; // see RULE_08
			tx_holding_ready <= fifo_in_ready;
		end
	end
endmodule

`default_nettype wire

//--- rtl/spi_flag_pkg.sv
// Shared constants and types for the SPI status flag logic
package spi_flag_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_CONFIG_ONE = 8'hE8;
	localparam logic [7:0] ADDR_STATUS = 8'hEA;
	localparam logic [7:0] ADDR_TX_HOLD = 8'h9A;
	localparam logic [7:0] ADDR_RX_HOLD = 8'h9B;

	// ****************************************
	// Status and config fields
	// ****************************************
	localparam int BIT_BUSY = 7;
	localparam int BIT_MULTIMASTER_ERROR_FLAG = 6;
	localparam int BIT_OVERRUN = 5;
	localparam int BIT_READY = 4;
	localparam int BIT_FULL = 3;
	localparam int BIT_UNDERFLOW = 2;
	localparam int CFG_TRANSFER_IRQ_MODE = 0;
	localparam int CFG_OVERWRITE = 2;
	localparam int CFG_SS_IN_EN = 3;
	localparam logic [7:0] CONFIG_RESET = 8'h01;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// ****************************************
	// Link and buffer sizes
	// ****************************************
	localparam int DATA_W = 8;
	localparam int TX_FIFO_DEPTH = 4;
	localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
	localparam logic [2:0] BIT_CNT_ONE = 3'h1;
	localparam logic [2:0] BIT_CNT_LAST = 3'h7;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;

	typedef enum logic [1:0] {
		LINK_IDLE = 2'b01,
		LINK_SHIFT = 2'b10
	} link_state_e;

endpackage

//--- verif/spi_flag_sva.sv
// Port-level assertions for the SPI status flag logic
`timescale 1ns/1ps
`default_nettype none
module spi_flag_sva (
	input wire logic clk, // System clock
	input wire logic rstn, // Async reset, low
	input wire spi_flag_pkg::sfr_req_s sfr_req, // SFR access
	input wire logic [7:0] sfr_rdata, // Read data
	input wire logic ss_n, // Slave select pin
	input wire logic miso_oe, // Data out enable
	input wire logic master_active, // Master transfer
	input wire logic ss_out_n, // Master select drive
	input wire logic irq_enable, // Interrupt enable
	input wire logic irq // Interrupt request
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire logic [7:0] ad = sfr_req.addr;
	wire logic rd_st = sfr_req.rd && ad == spi_flag_pkg::ADDR_STATUS;
	wire logic rd_rx = sfr_req.rd && ad == spi_flag_pkg::ADDR_RX_HOLD;
	wire logic rd_bad = sfr_req.rd && !(ad inside {8'hE8, 8'hEA, 8'h9B});
	wire logic wr_mode = sfr_req.wr && ad == spi_flag_pkg::ADDR_CONFIG_ONE;
	// ****************************************
	// Checks
	// ****************************************
	// ****************************************
	sequence rx_read;
		ss_n[*4] ##0 rd_rx;
	endsequence
	sequence status_read;
		rd_st && ss_n;
	endsequence
	a_rx_read_clears: assert property (
		rx_read ##1 status_read |=> sfr_rdata[5:3] == 3'h0)
		else $error("flags survive holding read");
	a_status_low_bits: assert property (
		rd_st |=> sfr_rdata[1:0] == 2'h0)
		else $error("status bits 1:0 not zero");
	a_unmapped_zero: assert property (
		rd_bad |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (
		!sfr_req.rd |=> $stable(sfr_rdata))
		else $error("read data moved without read");
	a_irq_needs_en: assert property (
		irq |-> $past(irq_enable))
		else $error("interrupt while disabled");
	a_irq_mode_off: assert property (
		wr_mode && sfr_req.wdata[0] |-> ##2 !irq)
		else $error("interrupt with mode bit set");
	a_oe_idle: assert property (
		ss_n[*6] |-> !miso_oe)
		else $error("data out driven while deselected");
	a_oe_master: assert property (
		master_active[*2] |-> !miso_oe)
		else $error("data out driven in master transfer");
	a_ss_out_idle: assert property (
		(!master_active)[*2] |-> ss_out_n)
		else $error("select driven without master transfer");
endmodule
bind spi_status_flag_logic spi_flag_sva chk (.clk(clk), .rstn(rstn),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .ss_n(ss_n),
	.miso_oe(miso_oe), .master_active(master_active), .ss_out_n(ss_out_n),
	.irq_enable(irq_enable), .irq(irq));
`default_nettype wire

//--- verif/spi_master_model.sv
// External SPI master driving the slave link in mode 0
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
	output logic sclk, // Link clock, idle low
	output logic ss_n, // Slave select, low active
	output logic mosi, // Data to the slave
	input wire logic miso // Data from the slave
);
	logic [7:0] rx;
	initial
	begin
		sclk = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b1;
		rx = 8'h00;
	end
	// One byte, MSB first, 32 ns clock period
	task automatic send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--)
		begin
			mosi = b[i];
			#16 sclk = 1'b1;
			rx = {rx[6:0], miso};
			#16 sclk = 1'b0;
		end
		#32;
	endtask
	// Released data line flips so a stale value is never mistaken for data
	task automatic select(input logic on);
		ss_n = ~on;
		if (!on)
			mosi = ~mosi;
		#64;
	endtask
endmodule
`default_nettype wire

//--- verif/spi_status_flag_logic_tb.sv
// Self-checking bench for the SPI status flag logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module spi_status_flag_logic_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	spi_flag_pkg::sfr_req_s req = '0;
	logic master_active = 1'b0;
	logic irq_enable = 1'b0;
	wire logic sclk, ss_n, mosi, miso;
	logic [7:0] rdata, s, a, b;
	logic irq;
	wire logic oe, sso_n, txr;
	int errors = 0;
	int comparisons = 0;
	int seed = 80650;
	always #2 clk = ~clk;
	spi_status_flag_logic dut (.clk(clk), .rstn(rstn), .sfr_req(req),
		.sfr_rdata(rdata), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
		.miso(miso), .miso_oe(oe), .master_active(master_active),
		.ss_out_n(sso_n), .irq_enable(irq_enable), .irq(irq),
		.tx_holding_ready(txr));
	spi_master_model pm (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));
	// ****************************************
	// Bus tasks and expectations
	// ****************************************
	task automatic acc(input logic w, input logic [7:0] ad,
		input logic [7:0] d);
		@(negedge clk);
		req = '{w, ~w, ad, d};
		@(negedge clk);
		req = '0;
		@(negedge clk);
	endtask
	task automatic st();
		acc(1'b0, spi_flag_pkg::ADDR_STATUS, 8'h00);
		s = rdata;
	endtask
	function automatic logic [7:0] exp_hold(input logic ow,
		input logic [7:0] old, input logic [7:0] nw);
		return ow ? nw : old;
	endfunction
	task automatic report_and_stop();
		$display("%0d comparisons, %0d errors", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		errors++;
		report_and_stop();
	end
	initial
	begin
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		st();
		`CHK("status", 8'h00, s)
		`CHK("tx_room", 1'b1, txr)
		`CHK("select_idle", 1'b1, sso_n)
		acc(1'b0, 8'h10, 8'h00);
		`CHK("unmapped", 8'h00, rdata)
		$display("test reset done");
		repeat (3)
		begin
			a = $random(seed);
			b = $random(seed);
			acc(1'b1, spi_flag_pkg::ADDR_TX_HOLD, b);
			pm.select(1'b1);
			pm.send(a);
			st();
			`CHK("busy_ready", 2'b11, {s[7], s[4]})
			`CHK("oe_on", 1'b1, oe)
			pm.select(1'b0);
			`CHK("oe_off", 1'b0, oe)
			`CHK("miso", b, pm.rx)
			acc(1'b0, spi_flag_pkg::ADDR_RX_HOLD, 8'h00);
			`CHK("rx", a, rdata)
			st();
			`CHK("idle", 2'b00, {s[7], s[4]})
		end
		$display("test single done");
		for (int ow = 0; ow < 2; ow++)
		begin
			acc(1'b1, spi_flag_pkg::ADDR_CONFIG_ONE, {5'h00, ow[0], 2'h1});
			a = $random(seed);
			b = $random(seed);
			pm.select(1'b1);
			pm.send(a);
			pm.send(b);
			pm.select(1'b0);
			st();
			`CHK("overrun", 4'hF, s[5:2])
			acc(1'b0, spi_flag_pkg::ADDR_RX_HOLD, 8'h00);
			`CHK("hold", exp_hold(ow[0], a, b), rdata)
			acc(1'b1, spi_flag_pkg::ADDR_STATUS, 8'h00);
			st();
			`CHK("cleared", 4'h0, s[5:2])
		end
		$display("test overrun done");
		acc(1'b1, spi_flag_pkg::ADDR_CONFIG_ONE, 8'h00);
		for (int en = 1; en >= 0; en--)
		begin
			irq_enable = en[0];
			pm.select(1'b1);
			pm.send(a);
			pm.select(1'b0);
			`CHK("irq", en[0], irq)
			acc(1'b0, spi_flag_pkg::ADDR_RX_HOLD, 8'h00);
			`CHK("irq_clear", 1'b0, irq)
		end
		acc(1'b1, spi_flag_pkg::ADDR_CONFIG_ONE, 8'h01);
		$display("test irq done");
		acc(1'b1, spi_flag_pkg::ADDR_CONFIG_ONE, 8'h09);
		master_active = 1'b1;
		pm.select(1'b1);
		st();
		`CHK("multimaster_error_flag", 2'b11, s[7:6])
		`CHK("select_drive", 1'b0, sso_n)
		pm.select(1'b0);
		@(negedge clk);
		master_active = 1'b0;
		st();
		`CHK("mm_hold", 1'b1, s[6])
		`CHK("select_release", 1'b1, sso_n)
		acc(1'b1, spi_flag_pkg::ADDR_STATUS, 8'h00);
		st();
		`CHK("mm_clear", 1'b0, s[6])
		$display("test multimaster done");
		report_and_stop();
	end
endmodule
`default_nettype wire
